/* include/dcps_pkg.sv */
// Types of the clock-enable power-state block
package dcps_pkg;
	typedef enum logic [2:0] {
		DCPS_ACTIVE,
		DCPS_PRE_PD,
		DCPS_ACT_PD,
		DCPS_SELF_REF,
		DCPS_ILLEGAL
	} dcps_state_t;
endpackage

/* include/dcps_regs.svh */
// Constants for the clock-enable power-state block
`ifndef DCPS_REGS_SVH
`define DCPS_REGS_SVH
// Command encodings on {csN, rasN, casN, weN}
`define DCPS_CMD_LMR 4'h0
`define DCPS_CMD_REF 4'h1
`define DCPS_CMD_PRE 4'h2
`define DCPS_CMD_ACT 4'h3
`define DCPS_CMD_WR 4'h4
`define DCPS_CMD_RD 4'h5
`define DCPS_CMD_NOP 4'h7
// Mode register field positions
`define DCPS_MR_PD_BIT 12
`define DCPS_MR_WR_LSB 9
// Registration count for minimum CKE level time
`define DCPS_CKE_REG_CNT 3
// Exit delays in clocks
`define DCPS_XP_CLK 8'h02
`define DCPS_XARD_CLK 8'h02
`define DCPS_XARDS_CLK 8'h08
`define DCPS_XSNR_CLK 8'h20
`define DCPS_XSRD_CLK 8'hc8
`endif

/* rtl/dcps_exit_timer.sv */
// Down counter that releases command classes after power-state exit
`timescale 1ns/1ps
`default_nettype none
module dcps_exit_timer #(
	parameter int WIDTH = 8
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Load
	input wire logic load,
	input wire logic [WIDTH-1:0] loadValue,
	// Status
	output logic done
);
	logic [WIDTH-1:0] count;

	initial begin
		if (WIDTH < 2) $error("dcps_exit_timer: WIDTH too small");
	end

	// Count down to zero after a load
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			count <= '0;
		end else if (load) begin
			count <= loadValue;
		end else if (count != '0) begin
			count <= count - 1'b1;
		end
	end

	assign done = (count == '0);
endmodule
`default_nettype wire

/* rtl/dcps_power_ctrl.sv */
// Power-state tracker driven by CKE history and registered commands
`timescale 1ns/1ps
`default_nettype none
`include "dcps_regs.svh"

// Behaviour
// - Idle banks give precharge, else active power-down
// - Wait exit delay before non-READ commands
// - Fast exit READ waits short delay
// - Slow exit READ waits longer delay
// - Action from previous CKE, CKE, command
// - Power-down enter/exit only with NOP/DESELECT
// - Self refresh entry: REFRESH, CKE falls, idle
// - Self refresh exit only with NOP/DESELECT
// - No refresh performed during power-down
// - Termination ignored; off in self refresh
// - Unlisted combinations at a CKE edge flagged illegal; steady CKE never flagged
// - Write-precharge entry one clock after recovery; not timed here, a CKE fall while colBusy is high is flagged illegal
// - Recovery count is rounded-up clock ratio; the modeReg recovery field is not used here
// - Exit at first edge CKE high with NOP
// - Buffers off in power-down; DLL frozen in precharge power-down only
module dcps_power_ctrl #(
	parameter int BANKS = 8,
	parameter int BANK_W = 3
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_b,
	// Command pins, sampled on each rising edge
	input wire logic cke,
	input wire logic csN,
	input wire logic rasN,
	input wire logic casN,
	input wire logic weN,
	input wire logic a10,
	input wire logic [BANK_W-1:0] bankAddr,
	input wire logic odt,
	// Configuration
	input wire logic [12:0] modeReg, // Recovery field passes through untouched
	input wire logic colBusy,
	// Status
	output logic [2:0] powerState,
	output logic inPowerDown,
	output logic inSelfRefresh,
	output logic buffersOn,
	output logic dllFrozen,
	output logic odtEnabled,
	output logic nonReadAllowed,
	output logic readAllowed,
	output logic illegalSeq,
	output logic [BANKS-1:0] openRows
);
	dcps_pkg::dcps_state_t state;
	dcps_pkg::dcps_state_t next_state;
	logic ckePrev;
	logic [BANKS-1:0] next_openRows;
	logic nonReadDone;
	logic readDone;
	logic exitLoad;
	logic [7:0] nonReadDelay;
	logic [7:0] readDelay;
	logic next_illegal;

	initial begin
		if (BANKS < 1 || BANKS > (1 << BANK_W)) $error("dcps_power_ctrl: bad BANKS");
	end

	// Command decode
	wire [3:0] cmd = {csN, rasN, casN, weN};
	wire isNop = csN | (cmd == `DCPS_CMD_NOP);
	wire isRef = (cmd == `DCPS_CMD_REF);
	wire isAct = (cmd == `DCPS_CMD_ACT);
	wire isPre = (cmd == `DCPS_CMD_PRE);
	wire allIdle = (openRows == '0);
	wire ckeFall = ckePrev & ~cke;
	wire ckeRise = ~ckePrev & cke;
	wire inPd = (state == dcps_pkg::DCPS_PRE_PD) || (state == dcps_pkg::DCPS_ACT_PD);
	wire inSr = (state == dcps_pkg::DCPS_SELF_REF);
	wire slowExit = modeReg[`DCPS_MR_PD_BIT];

	// Per-bank open row tracking
	genvar b;
	generate
		for (b = 0; b < BANKS; b++) begin : g_bank
			wire hit = (bankAddr == BANK_W'(b));
			assign next_openRows[b] = (cke & ckePrev & isAct & hit) ? 1'b1 :
				(cke & ckePrev & isPre & (a10 | hit)) ? 1'b0 : openRows[b];
		end
	endgenerate

	// Transition selection from CKE history and command; odt takes no part
	always_comb begin
		next_state = state;
		next_illegal = 1'b0;
		case (state)
			dcps_pkg::DCPS_ACTIVE: begin
				if (ckeFall && isNop) begin
					next_state = allIdle ? dcps_pkg::DCPS_PRE_PD : dcps_pkg::DCPS_ACT_PD;
				end else if (ckeFall && isRef && allIdle) begin
					next_state = dcps_pkg::DCPS_SELF_REF;
				end else if (ckeFall || ckeRise) begin
					next_illegal = 1'b1;
				end
			end
			dcps_pkg::DCPS_PRE_PD, dcps_pkg::DCPS_ACT_PD: begin
				// Held while CKE stays low; no refresh runs here
				if (ckeRise && isNop) begin
					next_state = dcps_pkg::DCPS_ACTIVE;
				end else if (ckeRise) begin
					next_illegal = 1'b1;
				end
			end
			dcps_pkg::DCPS_SELF_REF: begin
				if (ckeRise && isNop) begin
					next_state = dcps_pkg::DCPS_ACTIVE;
				end else if (ckeRise) begin
					next_illegal = 1'b1;
				end
			end
			default: begin
				next_state = dcps_pkg::DCPS_ACTIVE;
			end
		endcase
	end

	// Exit delays: non-READ and READ windows per mode
	assign exitLoad = (inPd || inSr) && (next_state == dcps_pkg::DCPS_ACTIVE);
	assign nonReadDelay = inSr ? `DCPS_XSNR_CLK : `DCPS_XP_CLK;
	assign readDelay = inSr ? `DCPS_XSRD_CLK :
		(state == dcps_pkg::DCPS_PRE_PD) ? `DCPS_XP_CLK :
		slowExit ? `DCPS_XARDS_CLK : `DCPS_XARD_CLK;

	dcps_exit_timer #(.WIDTH(8)) u_nonReadTimer (
		.clk(clk),
		.rst_b(rst_b),
		.load(exitLoad),
		.loadValue(nonReadDelay),
		.done(nonReadDone)
	);

	dcps_exit_timer #(.WIDTH(8)) u_readTimer (
		.clk(clk),
		.rst_b(rst_b),
		.load(exitLoad),
		.loadValue(readDelay),
		.done(readDone)
	);

	// State registers
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			state <= dcps_pkg::DCPS_ACTIVE;
			ckePrev <= 1'b1; // Active state implies CKE high; no false rise
			openRows <= '0;
			illegalSeq <= 1'b0;
		end else begin
			state <= next_state;
			ckePrev <= cke;
			openRows <= next_openRows;
			illegalSeq <= next_illegal | (ckeFall & colBusy);
		end
	end

	// Registered status outputs
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			powerState <= 3'h0;
			inPowerDown <= 1'b0;
			inSelfRefresh <= 1'b0;
			buffersOn <= 1'b1;
			dllFrozen <= 1'b0;
			odtEnabled <= 1'b1;
			nonReadAllowed <= 1'b1;
			readAllowed <= 1'b1;
		end else begin
			powerState <= next_state;
			inPowerDown <= (next_state == dcps_pkg::DCPS_PRE_PD) ||
				(next_state == dcps_pkg::DCPS_ACT_PD);
			inSelfRefresh <= (next_state == dcps_pkg::DCPS_SELF_REF);
			buffersOn <= (next_state == dcps_pkg::DCPS_ACTIVE);
			dllFrozen <= (next_state == dcps_pkg::DCPS_PRE_PD);
			odtEnabled <= (next_state != dcps_pkg::DCPS_SELF_REF);
			nonReadAllowed <= (next_state == dcps_pkg::DCPS_ACTIVE) && !exitLoad && nonReadDone;
			readAllowed <= (next_state == dcps_pkg::DCPS_ACTIVE) && !exitLoad && readDone;
		end
	end

	// Checks
	property p_pd_kind;
		@(posedge clk) disable iff (!rst_b)
		(state == dcps_pkg::DCPS_ACTIVE && ckeFall && isNop) |=>
			(inPowerDown && (dllFrozen == ($past(openRows) == '0)));
	endproperty
	a_pd_kind: assert property (p_pd_kind) else $error("wrong power-down kind");

	property p_sr_entry;
		@(posedge clk) disable iff (!rst_b)
		$rose(inSelfRefresh) |-> ($past(isRef) && ($past(openRows) == '0));
	endproperty
	a_sr_entry: assert property (p_sr_entry) else $error("bad self refresh entry");

	property p_sr_odt;
		@(posedge clk) disable iff (!rst_b)
		inSelfRefresh |-> !odtEnabled;
	endproperty
	a_sr_odt: assert property (p_sr_odt) else $error("termination in self refresh");

	property p_hold_pd;
		@(posedge clk) disable iff (!rst_b)
		(inPowerDown && !cke) |=> inPowerDown;
	endproperty
	a_hold_pd: assert property (p_hold_pd) else $error("power-down dropped");

	property p_exit;
		@(posedge clk) disable iff (!rst_b)
		(inPd && ckeRise && isNop) |=> (!inPowerDown && buffersOn);
	endproperty
	a_exit: assert property (p_exit) else $error("exit missed");

	property p_xsrd;
		@(posedge clk) disable iff (!rst_b)
		(inSr && ckeRise && isNop) |=> !readAllowed [*8];
	endproperty
	a_xsrd: assert property (p_xsrd) else $error("read released early");

	property p_slow;
		@(posedge clk) disable iff (!rst_b)
		(state == dcps_pkg::DCPS_ACT_PD && ckeRise && isNop && slowExit) |=>
			(!readAllowed [*8]) ##1 !readAllowed ##1 readAllowed;
	endproperty
	a_slow: assert property (p_slow) else $error("slow exit read timing");

	property p_fast;
		@(posedge clk) disable iff (!rst_b)
		(state == dcps_pkg::DCPS_ACT_PD && ckeRise && isNop && !slowExit) |=>
			!readAllowed ##1 !readAllowed ##1 !readAllowed ##1 readAllowed;
	endproperty
	a_fast: assert property (p_fast) else $error("fast exit read timing");

	property p_illegal;
		@(posedge clk) disable iff (!rst_b)
		(inPd && ckeRise && !isNop) |=> illegalSeq;
	endproperty
	a_illegal: assert property (p_illegal) else $error("illegal exit not flagged");
endmodule
`default_nettype wire

/* verification/dcps_ctrl_model.sv */
// Controller model driving clock-enable, command and termination pins
`timescale 1ns/1ps
`default_nettype none
module dcps_ctrl_model (
	// Clock
	input wire logic clk,
	// Pins toward the device
	output logic cke,
	output logic csN,
	output logic rasN,
	output logic casN,
	output logic weN,
	output logic a10,
	output logic [2:0] bankAddr,
	output logic odt
);
	// CKE idles low with NOP until the first request
	initial begin
		{cke, csN, rasN, casN, weN, a10, bankAddr, odt} = 10'h0e0;
	end
	// One request per clock after the falling edge; deselect leaves noise
	// Entries follow only ACT, PRE, REF or idle; no read data used
	task automatic issue(input logic k, input logic [3:0] cmd, input logic [2:0] bk,
		input logic ap);
		@(negedge clk);
		cke = k;
		{csN, rasN, casN, weN} = cmd[3] ? {1'b1, 3'($urandom)} : cmd;
		a10 = ap;
		bankAddr = bk;
		odt = 1'($urandom); // Termination set to a random level on each request
	endtask
endmodule
`default_nettype wire

/* verification/dcps_power_ctrl_tb.sv */
// Self-checking bench for the power-state tracker
`timescale 1ns/1ps
`default_nettype none
`include "dcps_regs.svh"
module dcps_power_ctrl_tb;
	logic clk, rst_b, cke, csN, rasN, casN, weN, a10, odt, colBusy, inPowerDown;
	logic inSelfRefresh, buffersOn, dllFrozen, odtEnabled, nonReadAllowed, readAllowed;
	logic illegalSeq, ckeP, nr, rd, eNr, eRd, nop;
	logic chkOn = 0;
	logic [2:0] bankAddr, powerState;
	logic [3:0] cmd;
	logic [7:0] openRows;
	logic [12:0] modeReg;
	int mismatches = 0;
	int totalChecks = 0;
	int st, opn, ill, nrc, rdc, eSt, eOpn, eIll;
	dcps_ctrl_model ctrl_u (.clk(clk), .cke(cke), .csN(csN), .rasN(rasN), .casN(casN),
		.weN(weN), .a10(a10), .bankAddr(bankAddr), .odt(odt));
	dcps_power_ctrl dut_u (.clk(clk), .rst_b(rst_b), .cke(cke), .csN(csN), .rasN(rasN),
		.casN(casN), .weN(weN), .a10(a10), .bankAddr(bankAddr), .odt(odt),
		.modeReg(modeReg), .colBusy(colBusy), .powerState(powerState),
		.inPowerDown(inPowerDown), .inSelfRefresh(inSelfRefresh), .buffersOn(buffersOn),
		.dllFrozen(dllFrozen), .odtEnabled(odtEnabled), .nonReadAllowed(nonReadAllowed),
		.readAllowed(readAllowed), .illegalSeq(illegalSeq), .openRows(openRows));
	// Clock
	initial begin
		clk = 0;
		forever #2.5 clk = ~clk;
	end
	// Reference model; expected ready flags trail each decision by one edge, expected state, open rows and illegal flag do not
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			{st, opn, ill, nrc, rdc, eSt, eOpn, eIll} = 0;
			{nr, rd, eNr, eRd, ckeP} = 5'h1f;
		end else begin
			{eNr, eRd} = {nr, rd};
			cmd = {csN, rasN, casN, weN};
			nop = csN || cmd == `DCPS_CMD_NOP;
			ill = 0;
			if (ckeP && !cke && colBusy) ill = 1;
			if (nrc > 0) begin
				nrc--;
				nr = nrc == 0;
			end
			if (rdc > 0) begin
				rdc--;
				rd = rdc == 0;
			end
			if (ckeP && cke) begin
				if (cmd == `DCPS_CMD_ACT) opn = opn | (1 << bankAddr);
				if (cmd == `DCPS_CMD_PRE) opn = a10 ? 0 : opn & ~(1 << bankAddr);
			end else if (ckeP) begin
				if (nop) st = (opn != 0) ? 2 : 1;
				else if (cmd == `DCPS_CMD_REF && opn == 0) st = 3;
				else ill = 1;
			end else if (cke && st != 0) begin
				if (!nop) ill = 1;
				else begin
					nrc = (st == 3) ? `DCPS_XSNR_CLK : `DCPS_XP_CLK;
					rdc = (st == 3) ? `DCPS_XSRD_CLK :
						(st == 1) ? `DCPS_XP_CLK : `DCPS_XARD_CLK;
					if (st == 2 && modeReg[12]) rdc = `DCPS_XARDS_CLK;
					nr = 0;
					rd = 0;
					eNr = 0;
					eRd = 0;
					st = 0;
				end
			end else if (cke && !ckeP) begin
				ill = 1;
			end
			ckeP = cke;
			{eSt, eOpn, eIll} = {st, opn, ill};
		end
	end
	// Compare every result once settled
	always @(negedge clk) begin
		if (chkOn) begin
			chk({powerState, openRows, illegalSeq, nonReadAllowed},
				{eSt[2:0], eOpn[7:0], eIll[0], eNr && eSt == 0});
			chk({inPowerDown, inSelfRefresh, odtEnabled}, {eSt == 1 || eSt == 2, eSt == 3, eSt != 3});
			chk({buffersOn, dllFrozen}, {eSt == 0, eSt == 1});
			chk(readAllowed, eRd && eSt == 0);
		end
	end
	task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
		totalChecks++;
		if (seen !== exp) begin
			mismatches++;
			$display("ERROR at %0t: seen %0h expected %0h", $time, seen, exp);
		end
	endtask
	task automatic hold(input logic k, input int n, input logic rnd);
		repeat (n) ctrl_u.issue(k, rnd ? 4'($urandom) : `DCPS_CMD_NOP, 0, 0);
	endtask
	task automatic results();
		$display("Checks %0d, mismatches %0d", totalChecks, mismatches);
		if (mismatches == 0 && totalChecks > 0) $display("RESULT: PASS");
		else $display("RESULT: FAIL");
		$finish;
	endtask
	// Watchdog
	initial begin
		repeat (3000) @(posedge clk);
		mismatches++;
		results();
	end
	// Stimulus
	initial begin
		void'($urandom(71526));
		{rst_b, colBusy, modeReg} = 0;
		repeat (10) @(posedge clk);
		ctrl_u.issue(1, `DCPS_CMD_NOP, 0, 0);
		rst_b = 1;
		chkOn = 1;
		hold(1, 4, 0);
		// Active power-down, fast then slow exit
		for (int m = 0; m < 2; m++) begin
			modeReg = {m[0], 12'($urandom)};
			ctrl_u.issue(1, `DCPS_CMD_ACT, 3'($urandom), 0);
			ctrl_u.issue(0, `DCPS_CMD_NOP, 0, 0);
			hold(0, 3, 1);
			ctrl_u.issue(1, 4'h8, 0, 0);
			hold(1, 10, 0);
		end
		// Precharge power-down, then refused entries with an open bank
		ctrl_u.issue(1, `DCPS_CMD_PRE, 0, 1);
		colBusy = 1;
		ctrl_u.issue(0, `DCPS_CMD_NOP, 0, 0);
		colBusy = 0;
		hold(0, 3, 1);
		ctrl_u.issue(1, `DCPS_CMD_NOP, 0, 0);
		hold(1, 3, 0);
		for (int c = 0; c < 6; c++) begin
			ctrl_u.issue(1, `DCPS_CMD_ACT, 3'($urandom), 0);
			hold(1, 2, 0);
			ctrl_u.issue(0, 4'(c), 0, 0);
			hold(0, 2, 0);
			hold(1, 3, 0);
		end
		// Self refresh and its long exit wait
		ctrl_u.issue(1, `DCPS_CMD_PRE, 0, 1);
		hold(1, 2, 0);
		ctrl_u.issue(0, `DCPS_CMD_REF, 0, 0);
		hold(0, 3, 1);
		ctrl_u.issue(1, `DCPS_CMD_NOP, 0, 0);
		hold(1, 205, 0);
		results();
	end
endmodule
`default_nettype wire
